/* core/gcm_glitchless_clock_mux.sv */
// Glitchless two-input clock multiplexer, oversampled on the system clock.
// Assumes clk is much faster than both input clocks; registers over Wishbone.
//
// The Wishbone interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
module gcm_glitchless_clock_mux
   import gcm_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic clk_in_a,
   input wire logic clk_in_b,
   input wire logic cascadeIn,
   output logic clkOut,
   output logic cascadeOut,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] sel_i,
   input wire logic [GCM_ADR_W-1:0] adr_i,
   input wire logic [GCM_DAT_W-1:0] dat_i,
   output logic [GCM_DAT_W-1:0] dat_o,
   output logic ack_o
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Qualifying edge: the transition that lands on the parked level
   function automatic logic qual_edge(input logic prev, input logic cur, input logic park);
      qual_edge = (prev != cur) && (cur == park);
   endfunction : qual_edge

   gcm_core_t st_reg;
   gcm_core_t st_next;
   gcm_wb_req_t wbReq;
   gcm_wb_rsp_t wbRsp;
   gcm_ctrl_t ctrl;
   gcm_cfg_t cfg;
   logic cfgLoad;
   logic [1:0] pinSync;
   logic [GCM_STATUS_W-1:0] status;
   logic levA;
   logic levB;
   logic pairA;
   logic pairB;
   logic enOnly;
   logic edgeA;
   logic edgeB;
   logic releaseA;
   logic releaseB;
   logic engageA;
   logic engageB;
   gcm_src_t wantNow;

   // ----------------------------------------------------------------
   // Pins and registers
   // ----------------------------------------------------------------
   gcm_pin_sync u_sync (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .pinIn({clk_in_b, clk_in_a}),
      .pinSync(pinSync)
   );

   assign wbReq = '{cyc: cyc_i, stb: stb_i, we: we_i, sel: sel_i, adr: adr_i, dat: dat_i};

   gcm_wb_regs u_regs (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .req(wbReq),
      .rsp(wbRsp),
      .status(status),
      .ctrl(ctrl),
      .cfg(cfg),
      .cfgLoad(cfgLoad)
   );

   assign dat_o = wbRsp.dat;
   assign ack_o = wbRsp.ack;

   // ----------------------------------------------------------------
   // Selection and hand-off
   // ----------------------------------------------------------------
   always_comb
   begin
      st_next = st_reg;
      levA = pinSync[0];
      // Neighbour output shares clk, so no synchroniser on it
      levB = ctrl.cascadeB ? cascadeIn : pinSync[1];
      pairA = ctrl.enableA && ctrl.selectA;
      pairB = ctrl.enableB && ctrl.selectB;
      enOnly = ctrl.selectA && ctrl.selectB;

      if (pairA && !pairB)
      begin
         wantNow = GCM_SRC_A;
      end
      else if (pairB && !pairA)
      begin
         wantNow = GCM_SRC_B;
      end
      else if (pairA && pairB)
      begin
         // Unusual state; the prior choice simply carries on
         wantNow = st_reg.want;
      end
      else
      begin
         wantNow = GCM_SRC_NONE;
      end

      edgeA = qual_edge(st_reg.lastA, levA, cfg.initOut);
      edgeB = qual_edge(st_reg.lastB, levB, cfg.initOut);

      // Release: bypass or enable-only skip the old clock's edge
      releaseA = st_reg.gateA && (wantNow != GCM_SRC_A) &&
                 (ctrl.bypassA || enOnly || (edgeA && !st_reg.syncA[1]));
      releaseB = st_reg.gateB && (wantNow != GCM_SRC_B) &&
                 (ctrl.bypassB || enOnly || (edgeB && !st_reg.syncB[1]));
      // Engage only once both gates are shut, on the new clock's edge
      engageA = !st_reg.gateA && !st_reg.gateB && edgeA && st_reg.syncA[1] &&
                (wantNow == GCM_SRC_A);
      engageB = !st_reg.gateA && !st_reg.gateB && edgeB && st_reg.syncB[1] &&
                (wantNow == GCM_SRC_B);

      st_next.lastA = levA;
      st_next.lastB = levB;
      st_next.want = wantNow;
      if (edgeA)
      begin
         st_next.syncA = {st_reg.syncA[0], wantNow == GCM_SRC_A};
      end
      if (edgeB)
      begin
         st_next.syncB = {st_reg.syncB[0], wantNow == GCM_SRC_B};
      end

      if (releaseA)
      begin
         st_next.gateA = 1'h0;
      end
      else if (engageA)
      begin
         st_next.gateA = 1'h1;
      end
      if (releaseB)
      begin
         st_next.gateB = 1'h0;
      end
      else if (engageB)
      begin
         st_next.gateB = 1'h1;
      end

      if (st_reg.gateA)
      begin
         st_next.clkOut = levA;
      end
      else if (st_reg.gateB)
      begin
         st_next.clkOut = levB;
      end
      else
      begin
         st_next.clkOut = cfg.initOut;
      end

      // A CONFIG write acts as configuration; A wins a double preselect
      if (cfgLoad)
      begin
         st_next.gateA = cfg.preselectA;
         st_next.gateB = cfg.preselectB && !cfg.preselectA;
         st_next.syncA = {2{cfg.preselectA}};
         st_next.syncB = {2{cfg.preselectB && !cfg.preselectA}};
         st_next.want = cfg.preselectA ? GCM_SRC_A : (cfg.preselectB ? GCM_SRC_B : GCM_SRC_NONE);
         st_next.clkOut = cfg.initOut;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         st_reg <= GCM_CORE_RST;
      end
      else if (ce)
      begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs and status
   // ----------------------------------------------------------------
   assign clkOut = st_reg.clkOut;
   assign cascadeOut = st_reg.clkOut;

   always_comb
   begin
      status = '0;
      status[GCM_STATUS_GATE_A] = st_reg.gateA;
      status[GCM_STATUS_GATE_B] = st_reg.gateB;
      status[GCM_STATUS_CLK_OUT] = st_reg.clkOut;
      status[GCM_STATUS_WANT_A] = st_reg.want == GCM_SRC_A;
      status[GCM_STATUS_WANT_B] = st_reg.want == GCM_SRC_B;
      status[GCM_STATUS_SWITCHING] = ((st_reg.want == GCM_SRC_A) != st_reg.gateA) ||
                                     ((st_reg.want == GCM_SRC_B) != st_reg.gateB);
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   route_a_a: assert property ((ce && st_reg.gateA && !cfgLoad) |=> clkOut == $past(levA))
      else $error("gated A not routed to output");

   hold_old_a: assert property ((ce && pairA && pairB && !cfgLoad) |=> st_reg.want == $past(st_reg.want))
      else $error("double selection changed the chosen input");

   park_level_a: assert property ((ce && !st_reg.gateA && !st_reg.gateB && !cfgLoad)
                                  |=> clkOut == $past(cfg.initOut))
      else $error("output not parked with no input gated");

   release_edge_a: assert property (($fell(st_reg.gateA) && !$past(cfgLoad) && !$past(ctrl.bypassA)
                                     && !$past(enOnly)) |-> $past(levA) == $past(cfg.initOut))
      else $error("A released off its qualifying edge");

   engage_edge_a: assert property (($rose(st_reg.gateB) && !$past(cfgLoad))
                                   |-> ($past(levB) == $past(cfg.initOut)) && !$past(st_reg.gateA))
      else $error("B engaged off edge or overlapping A");

   one_gate_a: assert property (!(st_reg.gateA && st_reg.gateB))
      else $error("both inputs gated at once");

   bypass_a_a: assert property ((ce && ctrl.bypassA && st_reg.gateA && wantNow != GCM_SRC_A && !cfgLoad)
                                |=> !st_reg.gateA)
      else $error("bypass A did not release at once");

   bypass_b_a: assert property ((ce && ctrl.bypassB && st_reg.gateB && wantNow != GCM_SRC_B && !cfgLoad)
                                |=> !st_reg.gateB)
      else $error("bypass B did not release at once");

   enable_only_a: assert property ((ce && enOnly && !cfgLoad &&
                                    ((st_reg.gateA && !pairA) || (st_reg.gateB && !pairB)))
                                   |=> !st_reg.gateA && !st_reg.gateB)
      else $error("enable-only switch waited for an edge");

   preselect_load_a: assert property ((ce && cfgLoad && cfg.preselectA) |=> st_reg.gateA ##1 clkOut == $past(levA))
      else $error("preselect A not applied");

   sync_chain_a: assert property (($rose(st_reg.gateA) && !$past(cfgLoad)) |-> $past(st_reg.syncA[1]))
      else $error("A engaged before its request chain settled");

   cascade_path_a: assert property ((ce && ctrl.cascadeB && st_reg.gateB && !cfgLoad)
                                    |=> clkOut == $past(cascadeIn))
      else $error("cascade input not routed");

   // B side mirrors, the A engage check and decode
   route_b_a: assert property ((ce && st_reg.gateB && !cfgLoad)
                               |=> clkOut == $past(levB))
      else $error("gated B not routed to output");

   want_a_a: assert property ((ce && pairA && !pairB && !cfgLoad)
                              |=> st_reg.want == GCM_SRC_A)
      else $error("full pair A not chosen");

   release_b_a: assert property (($fell(st_reg.gateB) && !$past(cfgLoad) && !$past(ctrl.bypassB)
                                  && !$past(enOnly))
                                 |-> $past(levB) == $past(cfg.initOut))
      else $error("B released off its qualifying edge");

   engage_a_a: assert property (($rose(st_reg.gateA) && !$past(cfgLoad))
                                |-> ($past(levA) == $past(cfg.initOut)) && !$past(st_reg.gateB))
      else $error("A engaged off edge or overlapping B");

   sync_b_a: assert property (($rose(st_reg.gateB) && !$past(cfgLoad))
                              |-> $past(st_reg.syncB[1]))
      else $error("B engaged before its request chain settled");

   // A frozen cycle must leave every flop alone
   ce_freeze_a: assert property (!ce |=> st_reg == $past(st_reg))
      else $error("state moved while clock enable was low");

endmodule : gcm_glitchless_clock_mux

/* core/gcm_pin_sync.sv */
// Two-flop synchroniser for the two input clock pins.
// Assumes the pins are asynchronous to clk; stage1 feeds stage2 only.
`timescale 1ns/1ps
module gcm_pin_sync
   import gcm_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [1:0] pinIn,
   output logic [1:0] pinSync
);

   gcm_sync_t st_reg;
   gcm_sync_t st_next;

   always_comb
   begin
      st_next = st_reg;
      st_next.stage1 = pinIn;
      st_next.stage2 = st_reg.stage1;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         st_reg <= GCM_SYNC_RST;
      end
      else if (ce)
      begin
         st_reg <= st_next;
      end
   end

   assign pinSync = st_reg.stage2;

endmodule : gcm_pin_sync

/* core/gcm_pkg.sv */
// Constants, register map and carrier types of the glitchless clock mux.
// Assumes a single 250 MHz system clock; both input clocks arrive as pins.
package gcm_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam int GCM_ADR_W = 8;
   localparam int GCM_DAT_W = 32;
   localparam logic [7:0] GCM_CTRL_OFS = 8'h00;
   localparam logic [7:0] GCM_CFG_OFS = 8'h04;
   localparam logic [7:0] GCM_STATUS_OFS = 8'h08;

   // CTRL fields
   localparam int GCM_CTRL_W = 7;
   localparam int GCM_CTRL_ENABLE_A = 0;
   localparam int GCM_CTRL_SELECT_A = 1;
   localparam int GCM_CTRL_ENABLE_B = 2;
   localparam int GCM_CTRL_SELECT_B = 3;
   localparam int GCM_CTRL_BYPASS_A = 4;
   localparam int GCM_CTRL_BYPASS_B = 5;
   localparam int GCM_CTRL_CASCADE_B = 6;
   localparam logic [6:0] GCM_CTRL_RST = 7'h00;

   // CONFIG fields
   localparam int GCM_CFG_W = 3;
   localparam int GCM_CFG_INIT_OUT = 0;
   localparam int GCM_CFG_PRESELECT_A = 1;
   localparam int GCM_CFG_PRESELECT_B = 2;
   localparam logic [2:0] GCM_CFG_RST = 3'h0;

   // STATUS fields
   localparam int GCM_STATUS_W = 6;
   localparam int GCM_STATUS_GATE_A = 0;
   localparam int GCM_STATUS_GATE_B = 1;
   localparam int GCM_STATUS_CLK_OUT = 2;
   localparam int GCM_STATUS_WANT_A = 3;
   localparam int GCM_STATUS_WANT_B = 4;
   localparam int GCM_STATUS_SWITCHING = 5;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {GCM_SRC_NONE, GCM_SRC_A, GCM_SRC_B} gcm_src_t;

   // Member order mirrors the CTRL bit positions, MSB first
   typedef struct packed {
      logic cascadeB;
      logic bypassB;
      logic bypassA;
      logic selectB;
      logic enableB;
      logic selectA;
      logic enableA;
   } gcm_ctrl_t;

   typedef struct packed {
      logic preselectB;
      logic preselectA;
      logic initOut;
   } gcm_cfg_t;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [GCM_ADR_W-1:0] adr;
      logic [GCM_DAT_W-1:0] dat;
   } gcm_wb_req_t;

   typedef struct packed {
      logic ack;
      logic [GCM_DAT_W-1:0] dat;
   } gcm_wb_rsp_t;

   typedef struct packed {
      logic [1:0] stage1;
      logic [1:0] stage2;
   } gcm_sync_t;

   typedef struct packed {
      gcm_ctrl_t ctrl;
      gcm_cfg_t cfg;
      logic cfgLoad;
      logic ack;
      logic [GCM_DAT_W-1:0] dat;
   } gcm_wb_state_t;

   typedef struct packed {
      logic lastA;
      logic lastB;
      logic [1:0] syncA;
      logic [1:0] syncB;
      logic gateA;
      logic gateB;
      gcm_src_t want;
      logic clkOut;
   } gcm_core_t;

   localparam gcm_sync_t GCM_SYNC_RST = '0;
   localparam gcm_core_t GCM_CORE_RST = '0;

endpackage : gcm_pkg

/* core/gcm_wb_regs.sv */
// Classic Wishbone slave holding CTRL and CONFIG; STATUS is read back from the core.
// Assumes a single-cycle classic master; answers every address.
`timescale 1ns/1ps
module gcm_wb_regs
   import gcm_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input gcm_wb_req_t req,
   output gcm_wb_rsp_t rsp,
   input wire logic [GCM_STATUS_W-1:0] status,
   output gcm_ctrl_t ctrl,
   output gcm_cfg_t cfg,
   output logic cfgLoad
);

   gcm_wb_state_t st_reg;
   gcm_wb_state_t st_next;
   logic hit;

   // ----------------------------------------------------------------
   // Access decode
   // ----------------------------------------------------------------
   always_comb
   begin
      st_next = st_reg;
      st_next.ack = 1'h0;
      st_next.cfgLoad = 1'h0;
      // Ack high blocks a second hit on the held request
      hit = req.cyc && req.stb && !st_reg.ack;
      if (hit)
      begin
         st_next.ack = 1'h1;
         case (req.adr)
            GCM_CTRL_OFS: st_next.dat = {25'h0, st_reg.ctrl};
            GCM_CFG_OFS: st_next.dat = {29'h0, st_reg.cfg};
            GCM_STATUS_OFS: st_next.dat = {26'h0, status};
            default: st_next.dat = 32'h00000000;
         endcase
         if (req.we && req.sel[0])
         begin
            case (req.adr)
               GCM_CTRL_OFS: st_next.ctrl = gcm_ctrl_t'(req.dat[GCM_CTRL_W-1:0]);
               GCM_CFG_OFS:
               begin
                  st_next.cfg = gcm_cfg_t'(req.dat[GCM_CFG_W-1:0]);
                  st_next.cfgLoad = 1'h1;
               end
               default: st_next.cfgLoad = 1'h0;
            endcase
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         st_reg <= '{ctrl: gcm_ctrl_t'(GCM_CTRL_RST), cfg: gcm_cfg_t'(GCM_CFG_RST),
                     cfgLoad: 1'h0, ack: 1'h0, dat: 32'h00000000};
      end
      else if (ce)
      begin
         st_reg <= st_next;
      end
   end

   assign rsp = '{ack: st_reg.ack, dat: st_reg.dat};
   assign ctrl = st_reg.ctrl;
   assign cfg = st_reg.cfg;
   assign cfgLoad = st_reg.cfgLoad;

   // A frozen cycle holds ack, so only a running cycle must drop it
   ack_single_a: assert property (@(posedge clk) disable iff (rst) (ce && st_reg.ack) |=> !st_reg.ack)
      else $error("ack stood for more than one cycle");

endmodule : gcm_wb_regs

/* dv/gcm_clk_src.sv */
// Free-running input clock source for the clock mux.
// Assumes the bench gates runEn; a stopped clock holds its level.
`timescale 1ns/1ps
module gcm_clk_src #(
   parameter real HALF_NS = 20.0,
   parameter real START_NS = 0.0
)
(
   input wire logic runEn,
   output logic clkSrc
);
   initial
   begin
      clkSrc = 1'b0;
      #(START_NS);
      forever
      begin
         #(HALF_NS);
         // Unrelated phase to the system clock
         if (runEn)
            clkSrc = ~clkSrc;
      end
   end
endmodule : gcm_clk_src

/* dv/tb_glitchless_clock_mux.sv */
// Self-checking bench for the glitchless clock mux over Wishbone.
// Assumes registered one-cycle ack and the STATUS layout of gcm_pkg.
`timescale 1ns/1ps
module tb_glitchless_clock_mux
   import gcm_pkg::*;
;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [3:0] sel = 4'h0;
   logic [7:0] adr = 8'h00;
   logic [31:0] datW = 32'h0;
   logic [31:0] datO;
   logic ackO, clkOut, cascadeOut, clkInA, clkInB;
   logic runA = 1'b1;
   logic runB = 1'b1;
   logic cascadeIn = 1'b0;
   logic casPrev = 1'b0;
   logic [2:0] casCnt = 3'h0;
   logic lastOut = 1'b0;
   logic watch = 1'b0;
   int toggles = 0;
   int runLen = 0;
   int minRun = 1000;
   int errTotal = 0;
   int checksDone = 0;
   logic [31:0] rd;
   int n, i;

   always #2 clk = ~clk;

   gcm_clk_src #(.HALF_NS(20.0), .START_NS(1.3)) gcm_clk_src_a_inst (.runEn(runA), .clkSrc(clkInA));
   gcm_clk_src #(.HALF_NS(28.0), .START_NS(3.1)) gcm_clk_src_b_inst (.runEn(runB), .clkSrc(clkInB));

   gcm_glitchless_clock_mux gcm_glitchless_clock_mux_inst (.clk(clk), .rst(rst), .ce(ce),
      .clk_in_a(clkInA), .clk_in_b(clkInB), .cascadeIn(cascadeIn), .clkOut(clkOut),
      .cascadeOut(cascadeOut), .cyc_i(cyc), .stb_i(stb), .we_i(we), .sel_i(sel), .adr_i(adr),
      .dat_i(datW), .dat_o(datO), .ack_o(ackO));

   // ----------------------------------------------------------------
   // Output watch and cascade source
   // ----------------------------------------------------------------
   always @(posedge clk)
   begin
      casCnt <= (casCnt == 3'h5) ? 3'h0 : casCnt + 3'h1;
      if (casCnt == 3'h5)
         cascadeIn <= ~cascadeIn;
      casPrev <= cascadeIn;
      lastOut <= clkOut;
      if (clkOut !== lastOut)
      begin
         toggles <= toggles + 1;
         if (watch && runLen < minRun)
            minRun <= runLen;
         runLen <= 1;
      end
      else
         runLen <= runLen + 1;
   end

   task check(input logic [31:0] seen, input logic [31:0] exp);
   begin
      checksDone++;
      if (seen !== exp)
      begin
         errTotal++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   end
   endtask : check

   task end_of_test;
   begin
      if (errTotal == 0 && checksDone > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   end
   endtask : end_of_test

   // ----------------------------------------------------------------
   // Bus and helper tasks
   // ----------------------------------------------------------------
   task wbx(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      int k;
   begin
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      datW <= d;
      sel <= 4'hF;
      k = 0;
      do
      begin
         @(posedge clk);
         k++;
      end
      while (ackO !== 1'b1 && k < 50);
      check(k < 50, 1'b1);
      r = datO;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   end
   endtask : wbx

   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] dummy;
   begin
      wbx(1'b1, a, d, dummy);
   end
   endtask : wr

   // Polls STATUS; a stopped switch shows up as a miss
   task waitBit(input int idx, input logic val);
      int k;
   begin
      for (k = 0; k < 80; k++)
      begin
         wbx(1'b0, GCM_STATUS_OFS, 32'h0, rd);
         if (rd[idx] === val)
            break;
      end
      check(rd[idx], val);
   end
   endtask : waitBit

   // Output edges seen over 200 system clocks
   task countEdges(output int c);
      int t0;
   begin
      t0 = toggles;
      repeat (200) @(posedge clk);
      c = toggles - t0;
   end
   endtask : countEdges

   initial
   begin
      #300000;
      errTotal++;
      end_of_test;
   end

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial
   begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      for (i = 0; i < 4; i++)
      begin
         wbx(1'b0, 8'(i * 4), 32'h0, rd);
         check(rd, 32'h0);
      end
      check(clkOut, 1'b0);
      wr(GCM_CTRL_OFS, 32'h03);
      waitBit(GCM_STATUS_GATE_A, 1'b1);
      watch <= 1'b1;
      countEdges(n);
      check(n >= 36 && n <= 44, 1'b1);
      wbx(1'b0, GCM_CTRL_OFS, 32'h0, rd);
      check(rd, 32'h03);
      wr(GCM_CTRL_OFS, 32'h0C);
      waitBit(GCM_STATUS_GATE_A, 1'b0);
      waitBit(GCM_STATUS_GATE_B, 1'b1);
      countEdges(n);
      check(n >= 26 && n <= 31, 1'b1);
      // Both pairs full only on purpose here, never in normal use
      wr(GCM_CTRL_OFS, 32'h0F);
      countEdges(n);
      check(n >= 26 && n <= 31, 1'b1);
      waitBit(GCM_STATUS_GATE_B, 1'b1);
      wr(GCM_CTRL_OFS, 32'h00);
      waitBit(GCM_STATUS_GATE_B, 1'b0);
      countEdges(n);
      check(n, 32'h0);
      check(clkOut, 1'b0);
      watch <= 1'b0;
      check(minRun >= 4, 1'b1);
      wr(GCM_CFG_OFS, 32'h01);
      repeat (4) @(posedge clk);
      check(clkOut, 1'b1);
      wr(GCM_CTRL_OFS, 32'h03);
      waitBit(GCM_STATUS_GATE_A, 1'b1);
      countEdges(n);
      check(n >= 36 && n <= 44, 1'b1);
      wr(GCM_CTRL_OFS, 32'h00);
      waitBit(GCM_STATUS_GATE_A, 1'b0);
      repeat (4) @(posedge clk);
      check(clkOut, 1'b1);
      // One preselect at a time
      for (i = 1; i < 3; i++)
      begin
         wr(GCM_CFG_OFS, 32'(1 << i));
         waitBit(i - 1, 1'b1);
      end
      wr(GCM_CFG_OFS, 32'h00);
      wr(GCM_CTRL_OFS, 32'h03);
      waitBit(GCM_STATUS_GATE_A, 1'b1);
      runA <= 1'b0;
      wr(GCM_CTRL_OFS, 32'h0C);
      repeat (100) @(posedge clk);
      waitBit(GCM_STATUS_GATE_A, 1'b1);
      wr(GCM_CTRL_OFS, 32'h1C);
      waitBit(GCM_STATUS_GATE_B, 1'b1);
      runA <= 1'b1;
      runB <= 1'b0;
      wr(GCM_CTRL_OFS, 32'h23);
      waitBit(GCM_STATUS_GATE_A, 1'b1);
      runB <= 1'b1;
      wr(GCM_CTRL_OFS, 32'h0B);
      runA <= 1'b0;
      wr(GCM_CTRL_OFS, 32'h0E);
      waitBit(GCM_STATUS_GATE_B, 1'b1);
      runA <= 1'b1;
      runB <= 1'b0;
      wr(GCM_CTRL_OFS, 32'h4C);
      waitBit(GCM_STATUS_GATE_B, 1'b1);
      countEdges(n);
      check(n >= 30 && n <= 36, 1'b1);
      check(cascadeOut, casPrev);
      // Output frozen while clock enable is low, then resumes
      ce <= 1'b0;
      repeat (3) @(posedge clk);
      countEdges(n);
      ce <= 1'b1;
      check(n, 32'h0); // Clock enable
      countEdges(n);
      check(n >= 30 && n <= 36, 1'b1);
      end_of_test;
   end
endmodule : tb_glitchless_clock_mux
